// >>> include/tbscd_pkg.sv
// constants, types and modifier tables for the single-channel texel block decoder
`default_nettype none
package tbscd_pkg;
  localparam int BYTE_W    = 8;
  localparam int BLOCK_W   = 64;
  localparam int BYTE_CNT  = 8;
  localparam int BASE_HI   = 63;
  localparam int BASE_LO   = 56;
  localparam int MULT_HI   = 55;
  localparam int MULT_LO   = 52;
  localparam int TSEL_HI   = 51;
  localparam int TSEL_LO   = 48;
  localparam int IDX_TOP   = 47;
  localparam int IDX_W     = 3;
  localparam int PIX_W     = 4;
  localparam int BASE_W    = 8;
  localparam int MULT_W    = 4;
  localparam int MOD_W     = 5;
  localparam int SUM_W     = 14;
  localparam int OUT11_W   = 11;
  localparam int OUT16_W   = 16;
  localparam int OUT8_W    = 8;
  localparam int SCALE_SH  = 3;
  localparam int WIDEN_LO  = 6;
  localparam logic [2:0] HALF_FILL = 3'b100;
  localparam logic [3:0] MULT_ZERO = 4'h0;
  localparam logic signed [SUM_W-1:0] MAX11 = 14'sd2047;
  localparam logic signed [SUM_W-1:0] MAX8  = 14'sd255;
  localparam logic signed [SUM_W-1:0] MIN0  = 14'sd0;
  localparam int LATENCY   = 2;

  typedef logic signed [SUM_W-1:0] tbscd_sum_type;
  typedef logic signed [MOD_W-1:0] tbscd_mod_type;

  typedef enum logic {
    SINGLE_CHANNEL_11BIT_FORMAT = 1'b0,
    RGBA_ALPHA_8BIT_FORMAT      = 1'b1
  } tbscd_format_type;

  // sixteen signed eight-entry modifier sets, entry 0 leftmost
  localparam tbscd_mod_type MOD_TABLE [0:15][0:7] = '{
    '{-5'sd3, -5'sd6, -5'sd9,  -5'sd15, 5'sd2, 5'sd5, 5'sd8, 5'sd14},
    '{-5'sd3, -5'sd7, -5'sd10, -5'sd13, 5'sd2, 5'sd6, 5'sd9, 5'sd12},
    '{-5'sd2, -5'sd5, -5'sd8,  -5'sd13, 5'sd1, 5'sd4, 5'sd7, 5'sd12},
    '{-5'sd2, -5'sd4, -5'sd6,  -5'sd13, 5'sd1, 5'sd3, 5'sd5, 5'sd12},
    '{-5'sd3, -5'sd6, -5'sd8,  -5'sd12, 5'sd2, 5'sd5, 5'sd7, 5'sd11},
    '{-5'sd3, -5'sd7, -5'sd9,  -5'sd11, 5'sd2, 5'sd6, 5'sd8, 5'sd10},
    '{-5'sd4, -5'sd7, -5'sd8,  -5'sd11, 5'sd3, 5'sd6, 5'sd7, 5'sd10},
    '{-5'sd3, -5'sd5, -5'sd8,  -5'sd11, 5'sd2, 5'sd4, 5'sd7, 5'sd10},
    '{-5'sd2, -5'sd6, -5'sd8,  -5'sd10, 5'sd1, 5'sd5, 5'sd7, 5'sd9},
    '{-5'sd2, -5'sd5, -5'sd8,  -5'sd10, 5'sd1, 5'sd4, 5'sd7, 5'sd9},
    '{-5'sd2, -5'sd4, -5'sd8,  -5'sd10, 5'sd1, 5'sd3, 5'sd7, 5'sd9},
    '{-5'sd2, -5'sd5, -5'sd7,  -5'sd10, 5'sd1, 5'sd4, 5'sd6, 5'sd9},
    '{-5'sd3, -5'sd4, -5'sd7,  -5'sd10, 5'sd2, 5'sd3, 5'sd6, 5'sd9},
    '{-5'sd1, -5'sd2, -5'sd3,  -5'sd10, 5'sd0, 5'sd1, 5'sd2, 5'sd9},
    '{-5'sd4, -5'sd6, -5'sd8,  -5'sd9,  5'sd3, 5'sd5, 5'sd7, 5'sd8},
    '{-5'sd3, -5'sd5, -5'sd7,  -5'sd9,  5'sd2, 5'sd4, 5'sd6, 5'sd8}
  };
endpackage : tbscd_pkg
`default_nettype wire

// >>> logic/tbscd_decoder.sv
// two-stage decoder of one texel from a compressed single-channel block
`timescale 1ns/1ns
`default_nettype none
// Operation
// - lowest address byte is most significant
// - upper 16-bit header, lower 48-bit indices
// - base bits 63-56 shifted left three
// - fill vacated bits with 100, no adder
// - bits 51-48 select modifier table
// - pixel index picks entry from left
// - nonzero multiplier times modifier, shifted three
// - signed sum clamped to 0..2047
// - output is unsigned fixed point
// - 11-bit mode zero multiplier adds raw modifier
// - 16-bit result is x<<5 plus x>>6
// - wider outputs by replication, never truncated
// - alpha mode drops three bits, clamps 0..255
// - alpha mode zero multiplier gives zero term
// - sixteen fixed signed modifier tables held
// - indices packed from top, pixel a first
module tbscd_decoder (
  input  wire logic                              CORE_CLK,
  input  wire logic                              RST,
  input  wire logic                              IN_VALID,
  input  wire logic [tbscd_pkg::BLOCK_W-1:0]     IN_BLOCK_BYTES,
  input  wire logic [tbscd_pkg::PIX_W-1:0]       IN_PIXEL,
  input  wire tbscd_pkg::tbscd_format_type       IN_FORMAT,
  output var  logic                              OUT_VALID,
  output var  logic [tbscd_pkg::OUT11_W-1:0]     OUT_VALUE11,
  output var  logic [tbscd_pkg::OUT16_W-1:0]     OUT_VALUE16,
  output var  logic [tbscd_pkg::OUT8_W-1:0]      OUT_ALPHA8
);
  import tbscd_pkg::*;

  // clamp a signed sum to the 11-bit range
  function automatic logic [OUT11_W-1:0] range_limit_11bit(
    input tbscd_sum_type value
  );
    tbscd_sum_type lim;
    lim = value;
    if (value < MIN0) begin
      lim = MIN0;
    end else if (value > MAX11) begin
      lim = MAX11;
    end
    return lim[OUT11_W-1:0];
  endfunction : range_limit_11bit

  // clamp a signed value to the 8-bit range
  function automatic logic [OUT8_W-1:0] range_limit_8bit(
    input tbscd_sum_type value
  );
    tbscd_sum_type lim;
    lim = value;
    if (value < MIN0) begin
      lim = MIN0;
    end else if (value > MAX8) begin
      lim = MAX8;
    end
    return lim[OUT8_W-1:0];
  endfunction : range_limit_8bit

  logic [BLOCK_W-1:0]   block_word;
  logic [5:0]           idx_lsb;
  logic [IDX_W-1:0]     pixel_index;
  logic [MULT_W-1:0]    table_sel;

  logic                 s1_valid;
  tbscd_format_type     s1_format;
  logic [BASE_W-1:0]    s1_base;
  logic [MULT_W-1:0]    s1_mult;
  tbscd_mod_type        s1_mod;

  tbscd_sum_type        base_term;
  tbscd_sum_type        product;
  tbscd_sum_type        mod_term;
  tbscd_sum_type        sum;
  tbscd_sum_type        sum_shr;
  logic [OUT11_W-1:0]   next_value11;
  logic [OUT8_W-1:0]    next_alpha8;

  // byte lane k of the input holds the byte at address k
  always_comb begin
    block_word = '0;
    for (int k = 0; k < BYTE_CNT; k++) begin
      block_word[BLOCK_W-1-k*BYTE_W -: BYTE_W] =
        IN_BLOCK_BYTES[k*BYTE_W +: BYTE_W];
    end
  end

  // header fields above bit 47, pixel indices below
  always_comb begin
    table_sel   = block_word[TSEL_HI:TSEL_LO];
    idx_lsb     = 6'(IDX_TOP + 1 - IDX_W - IDX_W * int'(IN_PIXEL));
    pixel_index = block_word[idx_lsb +: IDX_W];
  end

  // stage one valid strobe
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      s1_valid <= 1'b0;
    end else begin
      s1_valid <= IN_VALID;
    end
  end

  // stage one fields, taken only with a valid request
  always_ff @(posedge CORE_CLK) begin
    if (IN_VALID) begin
      s1_format <= IN_FORMAT;
      s1_base   <= block_word[BASE_HI:BASE_LO];
      s1_mult   <= block_word[MULT_HI:MULT_LO];
      s1_mod    <= MOD_TABLE[table_sel][pixel_index];
    end
  end

  // base times eight plus four by bit insertion
  always_comb begin
    base_term = SUM_W'({s1_base, HALF_FILL});
  end

  // modifier term in fourteen-bit signed arithmetic
  always_comb begin
    product = SUM_W'(s1_mod) * SUM_W'($signed({1'b0, s1_mult}));
    if (s1_mult != MULT_ZERO) begin
      mod_term = product <<< SCALE_SH;
    end else if (s1_format == RGBA_ALPHA_8BIT_FORMAT) begin
      mod_term = MIN0;
    end else begin
      mod_term = SUM_W'(s1_mod);
    end
  end

  // sum, clamp and alpha truncation
  always_comb begin
    sum          = base_term + mod_term;
    sum_shr      = sum >>> SCALE_SH;
    next_value11 = range_limit_11bit(sum);
    next_alpha8  = range_limit_8bit(sum_shr);
  end

  // output valid strobe
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      OUT_VALID <= 1'b0;
    end else begin
      OUT_VALID <= s1_valid;
    end
  end

  // output data, held until the next result
  always_ff @(posedge CORE_CLK) begin
    if (s1_valid) begin
      OUT_VALUE11 <= next_value11;
      OUT_VALUE16 <= (OUT16_W'(next_value11) << (OUT16_W - OUT11_W))
                   + OUT16_W'(next_value11 >> WIDEN_LO);
      OUT_ALPHA8  <= next_alpha8;
    end
  end

  // reference values for the checks below, worked in plain integers
  int exp_term;
  int exp_sum;
  int exp11;
  int exp8;
  int alpha_ref;

  always_comb begin
    exp_term = 0;
    if (s1_mult != MULT_ZERO) begin
      exp_term = int'(s1_mod) * int'(s1_mult) * (1 << SCALE_SH);
    end else if (s1_format == SINGLE_CHANNEL_11BIT_FORMAT) begin
      exp_term = int'(s1_mod);
    end
    exp_sum = int'(s1_base) * (1 << SCALE_SH) + int'(HALF_FILL) + exp_term;
    exp11   = exp_sum;
    if (exp_sum < 0) begin
      exp11 = 0;
    end else if (exp_sum > int'(MAX11)) begin
      exp11 = int'(MAX11);
    end
    exp8 = exp_sum >>> SCALE_SH;
    if (exp8 < 0) begin
      exp8 = 0;
    end else if (exp8 > int'(MAX8)) begin
      exp8 = int'(MAX8);
    end
    alpha_ref = int'(s1_base);
    if (s1_mult != MULT_ZERO) begin
      alpha_ref = alpha_ref + int'(s1_mod) * int'(s1_mult);
    end
    if (alpha_ref < 0) begin
      alpha_ref = 0;
    end else if (alpha_ref > int'(MAX8)) begin
      alpha_ref = int'(MAX8);
    end
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  valid_latency_a: assert property (
    IN_VALID |-> ##2 OUT_VALID
  ) else $error("result strobe missing two cycles after request");

  no_spurious_a: assert property (
    OUT_VALID |-> $past(IN_VALID, 2)
  ) else $error("result strobe without a request");

  reset_clears_a: assert property (
    @(posedge CORE_CLK) disable iff (1'b0) RST |=> !OUT_VALID && !s1_valid
  ) else $error("valid strobes not cleared by reset");

  byte_order_a: assert property (
    IN_VALID |=> s1_base == $past(IN_BLOCK_BYTES[7:0])
      && s1_mult == $past(IN_BLOCK_BYTES[15:12])
  ) else $error("base or multiplier taken from wrong byte");

  first_pixel_a: assert property (
    IN_VALID && IN_PIXEL == 4'h0 |=>
      s1_mod == MOD_TABLE[$past(IN_BLOCK_BYTES[11:8])][$past(IN_BLOCK_BYTES[23:21])]
  ) else $error("pixel a modifier mismatch");

  last_pixel_a: assert property (
    IN_VALID && IN_PIXEL == 4'hf |=>
      s1_mod == MOD_TABLE[$past(IN_BLOCK_BYTES[11:8])][$past(IN_BLOCK_BYTES[58:56])]
  ) else $error("pixel p modifier mismatch");

  value_11bit_a: assert property (
    s1_valid |=> int'(OUT_VALUE11) == $past(exp11)
  ) else $error("11-bit result mismatch");

  alpha_value_a: assert property (
    s1_valid |=> int'(OUT_ALPHA8) == $past(exp8)
  ) else $error("8-bit alpha result mismatch");

  zero_mult_a: assert property (
    s1_valid && s1_mult == 4'h0 && s1_format == RGBA_ALPHA_8BIT_FORMAT
      |=> OUT_ALPHA8 == $past(s1_base)
  ) else $error("alpha zero multiplier not zero term");

  widen_16_a: assert property (
    OUT_VALID |-> OUT_VALUE16 == {OUT_VALUE11, OUT_VALUE11[10:6]}
  ) else $error("16-bit widening mismatch");

  pixel_b_a: assert property (
    IN_VALID && IN_PIXEL == 4'h1 |=>
      s1_mod == MOD_TABLE[$past(IN_BLOCK_BYTES[11:8])][$past(IN_BLOCK_BYTES[20:18])]
  ) else $error("pixel b modifier mismatch");

  pixel_h_a: assert property (
    IN_VALID && IN_PIXEL == 4'h7 |=>
      s1_mod == MOD_TABLE[$past(IN_BLOCK_BYTES[11:8])][$past(IN_BLOCK_BYTES[34:32])]
  ) else $error("pixel h modifier mismatch");

  clamp_high_a: assert property (
    s1_valid && exp_sum > int'(MAX11) |=> OUT_VALUE11 == '1
  ) else $error("11-bit result not clamped to full scale");

  clamp_low_a: assert property (
    s1_valid && exp_sum < 0 |=> OUT_VALUE11 == '0
  ) else $error("11-bit result not clamped to zero");

  alpha_high_a: assert property (
    s1_valid && exp_sum > int'(MAX11) |=> OUT_ALPHA8 == '1
  ) else $error("alpha result not clamped to full scale");

  alpha_low_a: assert property (
    s1_valid && exp_sum < 0 |=> OUT_ALPHA8 == '0
  ) else $error("alpha result not clamped to zero");

  full_scale_a: assert property (
    OUT_VALID && OUT_VALUE11 == '1 |-> OUT_VALUE16 == '1
  ) else $error("full scale not kept by widening");

  raw_modifier_a: assert property (
    s1_valid && s1_mult == MULT_ZERO && s1_format == SINGLE_CHANNEL_11BIT_FORMAT
      && s1_base > 8'h01 && s1_base < 8'hfe
      |=> int'(OUT_VALUE11) == $past(int'(s1_base) * 8 + 4 + int'(s1_mod))
  ) else $error("zero multiplier did not add the raw modifier");

  alpha_direct_a: assert property (
    s1_valid && s1_format == RGBA_ALPHA_8BIT_FORMAT
      |=> int'(OUT_ALPHA8) == $past(alpha_ref)
  ) else $error("alpha result differs from base plus scaled modifier");

  data_hold_a: assert property (
    OUT_VALID && !s1_valid
      |=> $stable(OUT_VALUE11) && $stable(OUT_VALUE16) && $stable(OUT_ALPHA8)
  ) else $error("result data changed without a new result");

  lost_in_reset_a: assert property (
    @(posedge CORE_CLK) disable iff (1'b0) RST && IN_VALID |=> !s1_valid
  ) else $error("request taken during reset");

endmodule : tbscd_decoder
`default_nettype wire

// >>> dv/tbscd_fetch_model.sv
// fetch-side model that issues decode requests and notes expected results
`timescale 1ns/1ns
`default_nettype none
module tbscd_fetch_model (
  input  wire logic                          clk,
  input  wire logic [31:0]                   cyc,
  output var  logic                          req_valid,
  output var  logic [tbscd_pkg::BLOCK_W-1:0] req_bytes,
  output var  tbscd_pkg::tbscd_format_type   req_format,
  output var  logic [tbscd_pkg::PIX_W-1:0]   req_pixel
);
  import tbscd_pkg::*;
  logic [66:0] exp_q[$];
  initial begin
    req_valid = 1'b0;
    req_bytes = '0;
    req_format = SINGLE_CHANNEL_11BIT_FORMAT;
    req_pixel = '0;
  end
  task automatic send(input logic [63:0] w, input logic [3:0] p, input tbscd_format_type f);
    tbscd_sum_type s;
    tbscd_mod_type m;
    logic [10:0]   e11;
    logic [15:0]   e16;
    logic [7:0]    e8;
    @(negedge clk);
    m = MOD_TABLE[w[TSEL_HI:TSEL_LO]][w[IDX_TOP-3*p-:3]];
    s = tbscd_sum_type'({3'h0, w[BASE_HI:BASE_LO], 3'h4});
    if (w[MULT_HI:MULT_LO] != 4'h0) begin
      s = tbscd_sum_type'(s + m * $signed({1'b0, w[MULT_HI:MULT_LO]}) * 8);
    end else if (f == SINGLE_CHANNEL_11BIT_FORMAT) begin
      s = s + m;
    end
    e11 = (s < 0) ? 11'h0 : (s > 2047) ? 11'h7ff : s[10:0];
    e16 = {e11, 5'h0} + 16'(e11 >> 6);
    e8 = (s < 0) ? 8'h0 : (s > 2047) ? 8'hff : s[10:3];
    req_bytes = {<<8{w}};
    req_pixel = p;
    req_format = f;
    req_valid = 1'b1;
    exp_q.push_back({cyc + 32'(LATENCY), e11, e16, e8});
  endtask : send
  // released byte and pixel lines flip on each idle call so stale data never looks valid
  task automatic idle();
    @(negedge clk);
    req_valid = 1'b0;
    req_bytes = ~req_bytes;
    req_pixel = ~req_pixel;
  endtask : idle
endmodule : tbscd_fetch_model
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the texel block decoder
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import tbscd_pkg::*;
  logic             clk;
  logic             rst;
  logic [31:0]      cyc;
  logic [31:0]      lfsr;
  int               bad_count;
  int               compares;
  logic             in_valid;
  logic [63:0]      in_bytes;
  tbscd_format_type in_format;
  logic [3:0]       in_pixel;
  logic             out_valid;
  logic [10:0]      out11;
  logic [15:0]      out16;
  logic [7:0]       out8;
  logic [31:0]      at;
  logic [10:0]      x11;
  logic [15:0]      x16;
  logic [7:0]       x8;
  tbscd_fetch_model u_tbscd_fetch_model (.clk(clk), .cyc(cyc), .req_valid(in_valid),
    .req_bytes(in_bytes), .req_format(in_format), .req_pixel(in_pixel));
  tbscd_decoder u_tbscd_decoder (.CORE_CLK(clk), .RST(rst), .IN_VALID(in_valid),
    .IN_BLOCK_BYTES(in_bytes), .IN_PIXEL(in_pixel), .IN_FORMAT(in_format),
    .OUT_VALID(out_valid), .OUT_VALUE11(out11), .OUT_VALUE16(out16), .OUT_ALPHA8(out8));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  task automatic check_count(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
    end
  endtask : check_count
  task automatic check_value11(input logic [10:0] exp, input logic [10:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED value11 expected %0h seen %0h", exp, got);
    end
  endtask : check_value11
  task automatic check_value16(input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED value16 expected %0h seen %0h", exp, got);
    end
  endtask : check_value16
  task automatic check_alpha8(input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED alpha8 expected %0h seen %0h", exp, got);
    end
  endtask : check_alpha8
  function automatic logic [31:0] rnd();
    for (int i = 0; i < 32; i++) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  task automatic drain(input string name);
    u_tbscd_fetch_model.idle();
    for (int i = 0; i < 8 && u_tbscd_fetch_model.exp_q.size() > 0; i++) @(negedge clk);
    check_count("pending", 32'd0, 32'(u_tbscd_fetch_model.exp_q.size()));
    $display("test %s done", name);
  endtask : drain
  always @(posedge clk) begin
    cyc <= cyc + 32'd1;
    if (cyc == 32'd3000) begin
      bad_count++;
      complete_run();
    end
  end
  always @(negedge clk) begin
    if (out_valid !== 1'b0) begin
      if (u_tbscd_fetch_model.exp_q.size() == 0) begin
        check_count("spurious", 32'd0, 32'd1);
      end else begin
        {at, x11, x16, x8} = u_tbscd_fetch_model.exp_q.pop_front();
        check_count("latency", at, cyc);
        check_value11(x11, out11);
        check_value16(x16, out16);
        check_alpha8(x8, out8);
      end
    end
  end
  initial begin
    logic [63:0] w;
    logic [31:0] r;
    rst = 1'b1;
    cyc = 0;
    lfsr = 32'h3165b022;
    bad_count = 0;
    compares = 0;
    repeat (4) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    // worked examples: mult 2 and 0, both formats
    for (int k = 0; k < 4; k++) begin
      w = 64'h672d_0c00_0000_0000 & ~(64'(k[0]) << 53);
      u_tbscd_fetch_model.send(w, 4'h1, tbscd_format_type'(k[1]));
    end
    drain("directed");
    // every table, index and format, with clamp corners
    for (int k = 0; k < 512; k++) begin
      r = rnd();
      w = {rnd(), r};
      if (k[8]) w[63:52] = {{8{k[0]}}, 4'hf};
      else if (k % 5 == 0) w[55:52] = 4'h0;
      w[51:48] = k[3:0];
      w[IDX_TOP-3*r[3:0]-:3] = k[6:4];
      u_tbscd_fetch_model.send(w, r[3:0], tbscd_format_type'(k[7]));
      if (r[31:30] == 2'h0) u_tbscd_fetch_model.idle();
    end
    drain("sweep");
    // reset while two requests are in flight drops both
    u_tbscd_fetch_model.send(w, 4'h0, SINGLE_CHANNEL_11BIT_FORMAT);
    u_tbscd_fetch_model.send(~w, 4'hf, RGBA_ALPHA_8BIT_FORMAT);
    rst = 1'b1;
    u_tbscd_fetch_model.exp_q.delete();
    u_tbscd_fetch_model.idle();
    repeat (2) @(negedge clk);
    rst = 1'b0;
    u_tbscd_fetch_model.send(w, 4'h7, SINGLE_CHANNEL_11BIT_FORMAT);
    drain("reset");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
